// File: bench/remote_serial.sv
// behavioural remote serial device on the far side of the line
`timescale 1ns/1ns
module remote_serial #(parameter int BIT_CLKS = 16) (
	input wire clk_in,
	input wire txd_in,
	output logic rxd_out
);
	// line is pulled up: idle is mark
	initial rxd_out = 1'b1;
	task automatic bit_out(input logic b);
		rxd_out <= b;
		repeat (BIT_CLKS) @(posedge clk_in);
	endtask
	task automatic send(input logic [7:0] d, input logic par, input logic bad_par);
		@(posedge clk_in);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(d[i]);
		if (par)
			bit_out(^d ^ bad_par);
		bit_out(1'b1);
	endtask
	task automatic brk(input int bits);
		rxd_out <= 1'b0;
		repeat (bits * BIT_CLKS) @(posedge clk_in);
		rxd_out <= 1'b1;
	endtask
	// bounded wait; a timeout leaves a value the bench will reject
	task automatic recv(output logic [7:0] d);
		int n;
		n = 0;
		d = 8'hXX;
		while (txd_in !== 1'b0 && n < 3000) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 3000)
			return;
		repeat (BIT_CLKS / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_in);
			d[i] = txd_in;
		end
	endtask
endmodule // remote_serial

// File: bench/serial_port_asserts.sv
// assertions on the serial port request lines and register reads
`timescale 1ns/1ns
module serial_port_asserts (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire [7:0] addr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire rx_error_irq_out,
	input wire rx_full_irq_out,
	input wire tx_empty_irq_out,
	input wire tx_done_irq_out,
	input wire [3:0] irq_top_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// ------
	// priority
	// ------
	// two cycles of a level so a one-cycle lag of irq_top is tolerated
	a_prio_error: assert property (rx_error_irq_out [*2] |-> irq_top_out == 4'h8)
		else $error("irq_top not error");
	a_prio_full: assert property ((rx_full_irq_out && !rx_error_irq_out) [*2] |-> irq_top_out == 4'h4)
		else $error("irq_top not full");
	a_prio_empty: assert property ((tx_empty_irq_out && !rx_full_irq_out && !rx_error_irq_out) [*2]
		|-> irq_top_out == 4'h2) else $error("irq_top not empty");
	a_prio_done: assert property ((tx_done_irq_out && !tx_empty_irq_out && !rx_full_irq_out
		&& !rx_error_irq_out) [*2] |-> irq_top_out == 4'h1) else $error("irq_top not done");
	// ------
	// request versus flag
	// ------
	sequence s_rd_st;
		rd_in && addr_in == 8'h04;
	endsequence
	a_empty_flag_req: assert property (s_rd_st ##0 tx_empty_irq_out ##1 tx_empty_irq_out |-> rdata_out[0])
		else $error("empty request without flag");
	a_done_flag_req: assert property (s_rd_st ##0 tx_done_irq_out ##1 tx_done_irq_out |-> rdata_out[1])
		else $error("done request without flag");
	a_full_flag_req: assert property (s_rd_st ##0 rx_full_irq_out ##1 rx_full_irq_out |-> rdata_out[2])
		else $error("full request without flag");
	a_error_flag_req: assert property (s_rd_st ##0 rx_error_irq_out ##1 rx_error_irq_out |-> |rdata_out[5:3])
		else $error("error request without flag");
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside read slot");
endmodule // serial_port_asserts

bind serial_port serial_port_asserts chk_i (
	.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in),
	.addr_in(addr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.rx_error_irq_out(rx_error_irq_out),
	.rx_full_irq_out(rx_full_irq_out),
	.tx_empty_irq_out(tx_empty_irq_out),
	.tx_done_irq_out(tx_done_irq_out),
	.irq_top_out(irq_top_out)
);

// File: bench/test_serial_port_irq_and_error_logic.sv
// self-checking bench for serial port flags, requests and errors
`timescale 1ns/1ns
module test_serial_port_irq_and_error_logic;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	wire rxd;
	wire [7:0] rdata_out;
	wire txd_out;
	wire txd_oe_n_out;
	wire sclk_out;
	wire rx_error_irq_out;
	wire rx_full_irq_out;
	wire tx_empty_irq_out;
	wire tx_done_irq_out;
	wire [3:0] irq_top_out;
	int miscompares = 0;
	int n_tests = 0;
	logic [7:0] v;
	serial_port dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rxd_in(rxd), .rdata_out(rdata_out),
		.txd_out(txd_out), .txd_oe_n_out(txd_oe_n_out), .sclk_out(sclk_out),
		.rx_error_irq_out(rx_error_irq_out), .rx_full_irq_out(rx_full_irq_out),
		.tx_empty_irq_out(tx_empty_irq_out), .tx_done_irq_out(tx_done_irq_out), .irq_top_out(irq_top_out));
	remote_serial #(.BIT_CLKS(16)) far (.clk_in(clk_sys_in), .txd_in(txd_out), .rxd_out(rxd));
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// ------
	// helpers
	// ------
	task automatic close_out;
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(n, d, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic wst(input int b, input logic e);
		logic [7:0] d;
		for (int i = 0; i < 400; i++) begin
			rd(8'h04, d);
			if (d[b] === e)
				return;
		end
		chk("status wait", d[b], e);
		close_out;
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset;
		rchk("status", 8'h04, 8'h03);
		rchk("control", 8'h00, 8'h00);
		rchk("pin", 8'h14, 8'h04);
		rchk("unmapped", 8'hFF, 8'h00);
		chk("oe_n", txd_oe_n_out, 1'b1);
		chk("irqs", {rx_error_irq_out, rx_full_irq_out, tx_empty_irq_out, tx_done_irq_out}, 4'h0);
	endtask
	task automatic t_pin;
		wr(8'h14, 8'h03);
		tick(2);
		chk("oe_n", txd_oe_n_out, 1'b0);
		chk("txd", txd_out, 1'b1);
		wr(8'h14, 8'h01);
		tick(2);
		chk("txd break", txd_out, 1'b0);
		wr(8'h14, 8'h03);
	endtask
	task automatic t_tx;
		logic [7:0] g;
		wr(8'h10, 8'h00);
		wr(8'h00, 8'h0D);
		tick(3);
		chk("irq_top", irq_top_out, 4'h2);
		chk("done irq", tx_done_irq_out, 1'b1);
		wr(8'h08, 8'hA5);
		wr(8'h04, 8'hFC);
		fork
			far.recv(g);
			begin
				wst(0, 1'b1);
				chk("empty irq", tx_empty_irq_out, 1'b1);
				wr(8'h08, 8'h44);
				wr(8'h04, 8'hFE);
				wr(8'h08, 8'h55);
				tick(1);
				chk("empty irq off", tx_empty_irq_out, 1'b0);
			end
		join
		chk("frame 1", g, 8'hA5);
		far.recv(g);
		chk("frame 2", g, 8'h55);
		wst(1, 1'b1);
		tick(2);
		chk("done irq", tx_done_irq_out, 1'b1);
	endtask
	task automatic t_rx;
		wr(8'h00, 8'h12);
		far.send(8'h3C, 1'b0, 1'b0);
		tick(4);
		rchk("status full", 8'h04, 8'h07);
		chk("full irq", rx_full_irq_out, 1'b1);
		chk("irq_top", irq_top_out, 4'h4);
		far.send(8'h5A, 1'b0, 1'b0);
		tick(4);
		rchk("status overrun", 8'h04, 8'h0F);
		rchk("hold kept", 8'h0C, 8'h3C);
		chk("error irq", rx_error_irq_out, 1'b1);
		chk("irq_top", irq_top_out, 4'h8);
		wr(8'h04, 8'hC3);
		wr(8'h00, 8'h52);
		far.send(8'h69, 1'b1, 1'b1);
		tick(4);
		rchk("status parity", 8'h04, 8'h23);
		rchk("hold parity", 8'h0C, 8'h69);
		wr(8'h00, 8'h40);
		rchk("flags kept", 8'h04, 8'h23);
		wr(8'h04, 8'hC3);
		// odd parity with a matching parity bit must land as a clean word
		wr(8'h00, 8'hD2);
		far.send(8'h69, 1'b1, 1'b1);
		tick(4);
		rchk("odd parity", 8'h04, 8'h07);
		wr(8'h04, 8'hC3);
		wr(8'h00, 8'h02);
		far.send(8'h3C, 1'b0, 1'b0);
		tick(4);
		chk("masked irq", rx_full_irq_out, 1'b0);
		chk("irq_top none", irq_top_out, 4'h0);
		wr(8'h04, 8'hC3);
	endtask
	task automatic t_break;
		wr(8'h00, 8'h12);
		fork
			far.brk(30);
			begin
				tick(13 * 16);
				rchk("break framing", 8'h04, 8'h13);
				chk("error irq", rx_error_irq_out, 1'b1);
				rchk("break data", 8'h0C, 8'h00);
				wr(8'h04, 8'hC3);
				tick(12 * 16);
				rchk("framing again", 8'h04, 8'h13);
			end
		join
	endtask
	task automatic t_sync;
		tick(12 * 16);
		wr(8'h00, 8'h21);
		wr(8'h08, 8'hC3);
		wr(8'h04, 8'hFE);
		tick(40);
		rd(8'h04, v);
		chk("blocked", v[0], 1'b0);
		chk("sclk idle", sclk_out, 1'b1);
		wr(8'h00, 8'h20);
		rd(8'h04, v);
		chk("tx off empty", v[0], 1'b1);
		wr(8'h04, 8'hC2);
		wr(8'h00, 8'h21);
		// errors gone: clearing the empty flag must now start a frame
		wr(8'h04, 8'hFE);
		wst(0, 1'b1);
		chk("sclk running", sclk_out, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		tick(3);
		t_reset;
		t_pin;
		t_tx;
		t_rx;
		t_break;
		t_sync;
		close_out;
	end
endmodule // test_serial_port_irq_and_error_logic

// File: logic/serial_port.v
// serial port core: flags, interrupt requests, error handling, async and sync framing
`timescale 1ns/1ns
`include "serial_port_consts.vh"

module serial_port (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire rxd_in,
	output reg [7:0] rdata_out,
	output reg txd_out,
	output reg txd_oe_n_out,
	output reg sclk_out,
	output reg rx_error_irq_out,
	output reg rx_full_irq_out,
	output reg tx_empty_irq_out,
	output reg tx_done_irq_out,
	output reg [3:0] irq_top_out
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_START = 5'h02;
	localparam [4:0] S_DATA = 5'h04;
	localparam [4:0] S_PAR = 5'h08;
	localparam [4:0] S_STOP = 5'h10;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg rst_meta;
	reg rst_n;
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// registers and flags
	// ----------------------------------------
	reg [7:0] control;
	reg [7:0] baud_div;
	reg [1:0] pin_ctl;
	reg [7:0] tx_hold_buf;
	reg [7:0] rx_hold_buf;
	reg tx_buf_empty_flag;
	reg tx_done_flag;
	reg rx_buf_full_flag;
	reg overrun_flag;
	reg framing_error_flag;
	reg parity_error_flag;

	wire tx_on = control[`CTL_TX_ON];
	wire rx_on = control[`CTL_RX_ON];
	wire tx_empty_irq_on = control[`CTL_TX_EMPTY_IRQ_ON];
	wire tx_done_irq_on = control[`CTL_TX_DONE_IRQ_ON];
	wire rx_irq_on = control[`CTL_RX_IRQ_ON];
	wire sync_mode = control[`CTL_SYNC];
	wire par_on = control[`CTL_PAR_ON];
	wire par_odd = control[`CTL_PAR_ODD];
	wire pin_dir = pin_ctl[`PIN_DIR];
	wire pin_out_level = pin_ctl[`PIN_LEVEL];
	wire err_any = overrun_flag | framing_error_flag | parity_error_flag;
	wire [5:0] serial_status_word = {parity_error_flag, framing_error_flag, overrun_flag,
		rx_buf_full_flag, tx_done_flag, tx_buf_empty_flag};

	wire wr_status = wr_in && (addr_in == `ADDR_STATUS);

	// software clears a flag by writing 0 to it; writing 1 leaves it
	function clear_bit;
		input [7:0] data;
		input integer pos;
		begin
			clear_bit = wr_status & ~data[pos];
		end
	endfunction

	// ----------------------------------------
	// receive pin synchroniser
	// ----------------------------------------
	reg rxd_m1;
	reg rxd_m2;
	reg rxd_m3;
	reg rxd_s;
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rxd_m1 <= 1'b1;
			rxd_m2 <= 1'b1;
			rxd_m3 <= 1'b1;
			rxd_s <= 1'b1;
		end else begin
			rxd_m1 <= rxd_in;
			rxd_m2 <= rxd_m1;
			rxd_m3 <= rxd_m2;
			if (rxd_m2 == rxd_m3) begin
				rxd_s <= rxd_m3;
			end
		end
	end

	// ----------------------------------------
	// base clock: sixteen ticks per bit
	// ----------------------------------------
	reg [7:0] div_cnt;
	reg tick;
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (div_cnt >= baud_div) begin
			div_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	reg [4:0] tx_state;
	reg [3:0] tx_sub;
	reg [2:0] tx_bit;
	reg [7:0] tx_shift_buf;

	wire tx_last = tick && (tx_sub == `SUB_LAST);
	wire sync_rise = tick && sync_mode && (tx_state == S_DATA) && (tx_sub == `SUB_SAMPLE);
	// in sync mode a pending receive error holds the next frame back
	wire tx_load = tx_on && (tx_state == S_IDLE) && !tx_buf_empty_flag && !(sync_mode && err_any);
	wire tx_end = tx_on && tx_last && tx_buf_empty_flag &&
		((tx_state == S_STOP) || (sync_mode && (tx_state == S_DATA) && (tx_bit == `BIT_LAST)));

	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= S_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 3'h0;
			tx_shift_buf <= 8'h00;
			txd_out <= 1'b1;
			txd_oe_n_out <= 1'b1;
			sclk_out <= 1'b1;
		end else if (!tx_on) begin
			// abort whatever is in flight; pin falls back to a general port
			tx_state <= S_IDLE;
			tx_shift_buf <= 8'h00;
			tx_sub <= 4'h0;
			tx_bit <= 3'h0;
			txd_out <= pin_out_level;
			txd_oe_n_out <= ~pin_dir;
			sclk_out <= 1'b1;
		end else begin
			txd_oe_n_out <= 1'b0;
			if (tick && (tx_state != S_IDLE)) begin
				tx_sub <= tx_sub + 4'h1;
			end
			case (tx_state)
				S_IDLE: begin
					if (tx_load) begin
						tx_shift_buf <= tx_hold_buf;
						tx_sub <= 4'h0;
						tx_bit <= 3'h0;
						if (sync_mode) begin
							tx_state <= S_DATA;
							txd_out <= tx_hold_buf[0];
							sclk_out <= 1'b0;
						end else begin
							tx_state <= S_START;
							txd_out <= 1'b0;
						end
					end else if (!sync_mode) begin
						txd_out <= 1'b1;
					end
				end
				S_START: begin
					if (tx_last) begin
						tx_state <= S_DATA;
						txd_out <= tx_shift_buf[0];
					end
				end
				S_DATA: begin
					if (sync_rise) begin
						sclk_out <= 1'b1;
					end
					if (tx_last) begin
						if (tx_bit != `BIT_LAST) begin
							tx_bit <= tx_bit + 3'h1;
							txd_out <= tx_shift_buf[tx_bit + 3'h1];
							sclk_out <= ~sync_mode;
						end else if (sync_mode) begin
							// line keeps the last data bit
							tx_state <= S_IDLE;
						end else if (par_on) begin
							tx_state <= S_PAR;
							txd_out <= ^tx_shift_buf ^ par_odd;
						end else begin
							tx_state <= S_STOP;
							txd_out <= 1'b1;
						end
					end
				end
				S_PAR: begin
					if (tx_last) begin
						tx_state <= S_STOP;
						txd_out <= 1'b1;
					end
				end
				S_STOP: begin
					if (tx_last) begin
						tx_state <= S_IDLE;
					end
				end
				default: begin
					tx_state <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	reg [4:0] rx_state;
	reg [3:0] rx_sub;
	reg [2:0] rx_bit;
	reg [7:0] rx_shift_buf;
	reg rx_par;

	wire rx_sample = tick && (rx_sub == `SUB_SAMPLE);
	wire rx_done_async = rx_on && !sync_mode && (rx_state == S_STOP) && rx_sample;
	wire rx_done_sync = rx_on && sync_rise && (tx_bit == `BIT_LAST);
	wire rx_done = rx_done_async | rx_done_sync;
	wire [7:0] rx_word = sync_mode ? {rxd_s, rx_shift_buf[7:1]} : rx_shift_buf;
	wire rx_fer = rx_done_async && !rxd_s;
	wire rx_per = rx_done_async && par_on && (rx_par != (^rx_shift_buf ^ par_odd));

	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= S_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 3'h0;
			rx_shift_buf <= 8'h00;
			rx_par <= 1'b0;
		end else if (!rx_on || sync_mode) begin
			rx_state <= S_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 3'h0;
			if (rx_on && sync_rise) begin
				rx_shift_buf <= {rxd_s, rx_shift_buf[7:1]};
			end
		end else if (tick) begin
			rx_sub <= rx_sub + 4'h1;
			case (rx_state)
				S_IDLE: begin
					// low level restarts, so a held break frames again and again
					rx_sub <= 4'h0;
					if (!rxd_s) begin
						rx_state <= S_START;
					end
				end
				S_START: begin
					if (rx_sample && rxd_s) begin
						rx_state <= S_IDLE;
					end else if (rx_sub == `SUB_LAST) begin
						rx_state <= S_DATA;
						rx_bit <= 3'h0;
					end
				end
				S_DATA: begin
					if (rx_sample) begin
						rx_shift_buf <= {rxd_s, rx_shift_buf[7:1]};
					end
					if (rx_sub == `SUB_LAST) begin
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == `BIT_LAST) begin
							rx_state <= par_on ? S_PAR : S_STOP;
						end
					end
				end
				S_PAR: begin
					if (rx_sample) begin
						rx_par <= rxd_s;
					end
					if (rx_sub == `SUB_LAST) begin
						rx_state <= S_STOP;
					end
				end
				S_STOP: begin
					if (rx_sample) begin
						rx_state <= S_IDLE;
					end
				end
				default: begin
					rx_state <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// status flags: hardware set wins over software clear
	// ----------------------------------------
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_empty_flag <= 1'b1;
			tx_done_flag <= 1'b1;
			rx_buf_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			rx_hold_buf <= 8'h00;
		end else begin
			tx_buf_empty_flag <= ~tx_on | tx_load |
				(tx_buf_empty_flag & ~clear_bit(wdata_in, `ST_TX_EMPTY));
			tx_done_flag <= tx_end | (tx_done_flag & ~tx_load & ~clear_bit(wdata_in, `ST_TX_DONE));
			// overrun: keep old data and full flag, drop the new word
			overrun_flag <= (rx_done & rx_buf_full_flag) |
				(overrun_flag & ~clear_bit(wdata_in, `ST_OVERRUN));
			framing_error_flag <= rx_fer |
				(framing_error_flag & ~clear_bit(wdata_in, `ST_FRAMING));
			parity_error_flag <= rx_per |
				(parity_error_flag & ~clear_bit(wdata_in, `ST_PARITY));
			rx_buf_full_flag <= (rx_done & ~rx_fer & ~rx_per) | rx_buf_full_flag &
				~(clear_bit(wdata_in, `ST_RX_FULL) & ~rx_done);
			if (rx_done && !rx_buf_full_flag) begin
				rx_hold_buf <= rx_word;
			end
		end
	end

	// ----------------------------------------
	// register writes and reads
	// ----------------------------------------
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			control <= `RST_CONTROL;
			baud_div <= `RST_BAUD;
			pin_ctl <= `RST_PIN;
			tx_hold_buf <= 8'h00;
		end else if (wr_in) begin
			if (addr_in == `ADDR_CONTROL) begin
				control <= wdata_in;
			end else if (addr_in == `ADDR_TX_HOLD) begin
				tx_hold_buf <= wdata_in;
			end else if (addr_in == `ADDR_BAUD) begin
				baud_div <= wdata_in;
			end else if (addr_in == `ADDR_PIN) begin
				pin_ctl <= wdata_in[1:0];
			end
		end
	end

	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 8'h00;
		end else if (!rd_in) begin
			rdata_out <= 8'h00;
		end else if (addr_in == `ADDR_CONTROL) begin
			rdata_out <= control;
		end else if (addr_in == `ADDR_STATUS) begin
			rdata_out <= {2'h0, serial_status_word};
		end else if (addr_in == `ADDR_TX_HOLD) begin
			rdata_out <= tx_hold_buf;
		end else if (addr_in == `ADDR_RX_HOLD) begin
			rdata_out <= rx_hold_buf;
		end else if (addr_in == `ADDR_BAUD) begin
			rdata_out <= baud_div;
		end else if (addr_in == `ADDR_PIN) begin
			// live line level lets software spot a break
			rdata_out <= {5'h00, rxd_s, pin_ctl};
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	wire req_err = rx_irq_on & err_any;
	wire req_full = rx_irq_on & rx_buf_full_flag;
	wire req_empty = tx_empty_irq_on & tx_buf_empty_flag;
	wire req_done = tx_done_irq_on & tx_done_flag;

	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_error_irq_out <= 1'b0;
			rx_full_irq_out <= 1'b0;
			tx_empty_irq_out <= 1'b0;
			tx_done_irq_out <= 1'b0;
			irq_top_out <= 4'h0;
		end else begin
			rx_error_irq_out <= req_err;
			rx_full_irq_out <= req_full;
			tx_empty_irq_out <= req_empty;
			tx_done_irq_out <= req_done;
			if (req_err) begin
				irq_top_out <= 4'h8;
			end else if (req_full) begin
				irq_top_out <= 4'h4;
			end else if (req_empty) begin
				irq_top_out <= 4'h2;
			end else if (req_done) begin
				irq_top_out <= 4'h1;
			end else begin
				irq_top_out <= 4'h0;
			end
		end
	end

endmodule // serial_port

// File: logic/serial_port_consts.vh
// constants for the serial port status, interrupt and error logic
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_TX_HOLD 8'h08
`define ADDR_RX_HOLD 8'h0C
`define ADDR_BAUD 8'h10
`define ADDR_PIN 8'h14

// ----------------------------------------
// control word bits
// ----------------------------------------
`define CTL_TX_ON 0
`define CTL_RX_ON 1
`define CTL_TX_EMPTY_IRQ_ON 2
`define CTL_TX_DONE_IRQ_ON 3
`define CTL_RX_IRQ_ON 4
`define CTL_SYNC 5
`define CTL_PAR_ON 6
`define CTL_PAR_ODD 7

// ----------------------------------------
// status word bits
// ----------------------------------------
`define ST_TX_EMPTY 0
`define ST_TX_DONE 1
`define ST_RX_FULL 2
`define ST_OVERRUN 3
`define ST_FRAMING 4
`define ST_PARITY 5

// ----------------------------------------
// pin control bits
// ----------------------------------------
`define PIN_DIR 0
`define PIN_LEVEL 1
`define PIN_RXD 2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_BAUD 8'h00
`define RST_PIN 2'h0
`define SUB_SAMPLE 4'h7
`define SUB_LAST 4'hF
`define BIT_LAST 3'h7

`endif
